// ### verilog/ivm_cmd_core.sv
// Direct-mode handling of vector, handler return, user functions and the
// position-reached event; program-side handling of vector and handler return.
// Assumes whole frames on cmd_valid, one clk domain, and a motion
// core that pulses move_start and move_done for each positioning move.
`timescale 1ns/10ps
`default_nettype none
module ivm_cmd_core #(
  parameter int IRQS = ivm_pkg::IRQ_COUNT
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Direct-mode command frames
  input  wire logic                      cmd_valid,
  input  wire ivm_pkg::ivm_cmd_t         cmd,
  output logic                           cmd_ready,
  // Reply frames
  output logic                           reply_valid,
  output ivm_pkg::ivm_reply_t            reply,
  input  wire logic                      reply_ready,
  // Stored-program instruction issue
  input  wire logic                      prog_valid,
  input  wire ivm_pkg::ivm_cmd_t         prog_cmd,
  // Live interpreter context
  input  wire ivm_pkg::ivm_ctx_t         ctx_live,
  // Interrupt sources, one-cycle pulses
  input  wire logic [IRQS-1:0]           irq_event,
  // Program counter control
  output logic                           pc_load,
  output logic [ivm_pkg::PC_W-1:0]       pc_value,
  output logic                           ctx_restore,
  output ivm_pkg::ivm_ctx_t              ctx_saved,
  output logic                           in_handler,
  // User function hand-off
  output logic                           user_fn_strobe,
  output logic [2:0]                     user_fn_index,
  input  wire logic [31:0]               user_fn_result,
  // Motion core
  input  wire logic                      move_start,
  input  wire logic                      move_done
);
  localparam int PW = ivm_pkg::PC_W;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [PW-1:0]        vec_r [IRQS];
  logic [IRQS-1:0]      vec_ok_r;
  logic [IRQS-1:0]      irq_en_r;
  logic                 irq_glob_r;
  logic [IRQS-1:0]      irq_pend_r;
  ivm_pkg::ivm_ctx_t    ctx_r;
  logic                 in_handler_r;
  logic                 pc_load_r;
  logic [PW-1:0]        pc_value_r;
  logic                 ctx_restore_r;
  logic                 ev_every_r;
  logic                 ev_once_r;
  logic                 ev_track_r;
  logic                 ev_due_r;
  logic [7:0]           ev_mask_r;
  logic                 rep_valid_r;
  ivm_pkg::ivm_reply_t  rep_r;
  logic                 uf_strobe_r;
  logic [2:0]           uf_index_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic [7:0] cmd_sum;
  logic [7:0] rep_sum;
  logic       take_cmd;
  logic       sum_ok;
  logic       is_define_vector_cmd;
  logic       is_return_from_handler_cmd;
  logic       is_user;
  logic       is_event;
  logic       is_en;
  logic       is_dis;
  logic       evt_type_ok;
  logic       irq_idx_ok;
  logic [IRQS-1:0] irq_sel;

  ivm_sum8 u_cmd_sum (
    .frame (cmd),
    .sum   (cmd_sum)
  );

  assign cmd_ready   = ~rep_valid_r;
  assign take_cmd    = cmd_valid & cmd_ready;
  assign sum_ok      = (cmd_sum == cmd.checksum);
  assign is_define_vector_cmd     = (cmd.opcode == ivm_pkg::OP_DEFINE_VECTOR);
  assign is_return_from_handler_cmd     = (cmd.opcode == ivm_pkg::OP_RETURN_HANDLER);
  assign is_user     = (cmd.opcode >= ivm_pkg::OP_USER_FIRST) &&
                       (cmd.opcode <= ivm_pkg::OP_USER_LAST);
  assign is_event    = (cmd.opcode == ivm_pkg::OP_POS_EVENT);
  assign is_en       = (cmd.opcode == ivm_pkg::OP_IRQ_ENABLE);
  assign is_dis      = (cmd.opcode == ivm_pkg::OP_IRQ_DISABLE);
  assign evt_type_ok = (cmd.kind == ivm_pkg::EVT_TYPE_ONCE) ||
                       (cmd.kind == ivm_pkg::EVT_TYPE_EVERY);
  assign irq_idx_ok  = (cmd.kind < 8'(IRQS));
  assign irq_sel     = irq_idx_ok ? (IRQS'(1) << cmd.kind[ivm_pkg::IRQ_IDX_W-1:0])
                                  : '0;

  // Program path: event request has no program form and is ignored there
  logic       p_define_vector_cmd;
  logic       p_return_from_handler_cmd;
  logic       p_en;
  logic       p_dis;
  logic       p_idx_ok;
  logic [IRQS-1:0] p_sel;
  assign p_define_vector_cmd   = prog_valid && (prog_cmd.opcode == ivm_pkg::OP_DEFINE_VECTOR);
  assign p_return_from_handler_cmd   = prog_valid && (prog_cmd.opcode == ivm_pkg::OP_RETURN_HANDLER);
  assign p_en     = prog_valid && (prog_cmd.opcode == ivm_pkg::OP_IRQ_ENABLE);
  assign p_dis    = prog_valid && (prog_cmd.opcode == ivm_pkg::OP_IRQ_DISABLE);
  assign p_idx_ok = (prog_cmd.kind < 8'(IRQS));
  assign p_sel    = p_idx_ok ? (IRQS'(1) << prog_cmd.kind[ivm_pkg::IRQ_IDX_W-1:0]) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Vector table
  logic d_define_vector_cmd_ok;
  assign d_define_vector_cmd_ok = take_cmd && sum_ok && is_define_vector_cmd && irq_idx_ok;

  always_ff @(posedge clk) begin
    for (int i = 0; i < IRQS; i++) begin
      if (d_define_vector_cmd_ok && irq_sel[i]) begin
        vec_r[i] <= cmd.value[PW-1:0];
      end else if (p_define_vector_cmd && p_sel[i]) begin
        vec_r[i] <= prog_cmd.value[PW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables and pending
  logic en_hit;
  logic dis_hit;
  logic glob_on;
  logic glob_off;
  assign en_hit   = (take_cmd && sum_ok && is_en) || p_en;
  assign dis_hit  = (take_cmd && sum_ok && is_dis) || p_dis;
  assign glob_on  = (take_cmd && sum_ok && is_en && cmd.kind == ivm_pkg::IRQ_GLOBAL) ||
                    (p_en && prog_cmd.kind == ivm_pkg::IRQ_GLOBAL);
  assign glob_off = (take_cmd && sum_ok && is_dis && cmd.kind == ivm_pkg::IRQ_GLOBAL) ||
                    (p_dis && prog_cmd.kind == ivm_pkg::IRQ_GLOBAL);

  logic [IRQS-1:0] en_sel;
  assign en_sel = (take_cmd && sum_ok && (is_en || is_dis)) ? irq_sel : p_sel;

  // Lowest pending, enabled, vectored source wins
  logic [IRQS-1:0] eligible;
  logic            take_irq;
  logic [ivm_pkg::IRQ_IDX_W-1:0] irq_pick;
  assign eligible = irq_pend_r & irq_en_r & vec_ok_r;
  assign take_irq = irq_glob_r && !in_handler_r && (eligible != '0);

  always_comb begin
    irq_pick = '0;
    for (int i = IRQS - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        irq_pick = ivm_pkg::IRQ_IDX_W'(i);
      end
    end
  end

  logic leave_handler;
  assign leave_handler = in_handler_r &&
                         ((take_cmd && sum_ok && is_return_from_handler_cmd) || p_return_from_handler_cmd);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_ok_r   <= '0;
      irq_en_r   <= '0;
      irq_glob_r <= 1'b0;
      irq_pend_r <= '0;
    end else begin
      vec_ok_r   <= vec_ok_r | (d_define_vector_cmd_ok ? irq_sel : '0) | (p_define_vector_cmd ? p_sel : '0);
      irq_en_r   <= (irq_en_r & ~(dis_hit ? en_sel : '0)) | (en_hit ? en_sel : '0);
      irq_glob_r <= glob_on ? 1'b1 : (glob_off ? 1'b0 : irq_glob_r);
      // New event wins over the clear of the one taken
      irq_pend_r <= (irq_pend_r & ~(take_irq ? (IRQS'(1) << irq_pick) : '0)) | irq_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler entry and return
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctx_r         <= '0;
      in_handler_r  <= 1'b0;
      pc_load_r     <= 1'b0;
      pc_value_r    <= '0;
      ctx_restore_r <= 1'b0;
    end else begin
      pc_load_r     <= 1'b0;
      ctx_restore_r <= 1'b0;
      if (take_irq) begin
        ctx_r        <= ctx_live;
        in_handler_r <= 1'b1;
        pc_load_r    <= 1'b1;
        pc_value_r   <= vec_r[irq_pick];
      end else if (leave_handler) begin
        in_handler_r  <= 1'b0;
        ctx_restore_r <= 1'b1;
        pc_load_r     <= 1'b1;
        pc_value_r    <= ctx_r.pc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position-reached arming
  logic ev_req;
  logic ev_fire;
  assign ev_req  = take_cmd && sum_ok && is_event && evt_type_ok;
  assign ev_fire = ev_track_r && move_done;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_every_r <= 1'b0;
      ev_once_r  <= 1'b0;
      ev_track_r <= 1'b0;
      ev_due_r   <= 1'b0;
      ev_mask_r  <= '0;
    end else begin
      if (ev_req) begin
        ev_mask_r  <= {7'b000_0000, cmd.value[ivm_pkg::MOTOR_BIT]};
        ev_every_r <= (cmd.kind == ivm_pkg::EVT_TYPE_EVERY);
        ev_once_r  <= (cmd.kind == ivm_pkg::EVT_TYPE_ONCE);
      end else if (move_start && ev_once_r) begin
        ev_once_r  <= 1'b0;
      end
      if (move_start) begin
        ev_track_r <= (ev_every_r || ev_once_r) && (ev_mask_r != '0);
      end else if (move_done) begin
        ev_track_r <= 1'b0;
      end
      // Completion wins over the send that clears it
      ev_due_r <= ev_fire | (ev_due_r & ~(rep_valid_r & reply_ready & rep_r.status ==
                  ivm_pkg::ST_POS_REACHED));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply building
  ivm_pkg::ivm_reply_t rep_nxt;
  logic [7:0]          rep_nxt_sum;
  logic                send_due;
  assign send_due = ev_due_r && !rep_valid_r && !take_cmd;

  always_comb begin
    rep_nxt        = '0;
    rep_nxt.host   = ivm_pkg::HOST_ADDR;
    rep_nxt.target = ivm_pkg::MODULE_ADDR;
    rep_nxt.opcode = cmd.opcode;
    rep_nxt.status = ivm_pkg::ST_OK;
    if (send_due) begin
      rep_nxt.opcode = ivm_pkg::OP_POS_EVENT;
      rep_nxt.status = ivm_pkg::ST_POS_REACHED;
      rep_nxt.value  = {24'h00_0000, ev_mask_r};
    end else if (!sum_ok) begin
      rep_nxt.status = ivm_pkg::ST_BAD_CHECKSUM;
    end else if (is_event) begin
      rep_nxt.status = evt_type_ok ? ivm_pkg::ST_OK : ivm_pkg::ST_BAD_TYPE;
      rep_nxt.value  = {24'h00_0000, 7'b000_0000, cmd.value[ivm_pkg::MOTOR_BIT]};
    end else if (is_user) begin
      rep_nxt.value  = user_fn_result;
    end else if (is_define_vector_cmd || is_return_from_handler_cmd || is_en || is_dis) begin
      rep_nxt.status = ivm_pkg::ST_OK;
    end else begin
      rep_nxt.status = ivm_pkg::ST_BAD_OPCODE;
    end
  end

  ivm_sum8 u_rep_sum (
    .frame ({rep_nxt.host, rep_nxt.target, rep_nxt.status, rep_nxt.opcode,
             rep_nxt.value, 8'h00}),
    .sum   (rep_nxt_sum)
  );
  assign rep_sum = rep_nxt_sum;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rep_valid_r <= 1'b0;
      rep_r       <= '0;
      uf_strobe_r <= 1'b0;
      uf_index_r  <= '0;
    end else begin
      uf_strobe_r <= take_cmd && sum_ok && is_user;
      if (take_cmd && sum_ok && is_user) begin
        uf_index_r <= cmd.opcode[2:0];
      end
      if (take_cmd || send_due) begin
        rep_valid_r    <= 1'b1;
        rep_r          <= rep_nxt;
        rep_r.checksum <= rep_sum;
      end else if (reply_ready) begin
        rep_valid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reply_valid    = rep_valid_r;
  assign reply          = rep_r;
  assign pc_load        = pc_load_r;
  assign pc_value       = pc_value_r;
  assign ctx_restore    = ctx_restore_r;
  assign ctx_saved      = ctx_r;
  assign in_handler     = in_handler_r;
  assign user_fn_strobe = uf_strobe_r;
  assign user_fn_index  = uf_index_r;

endmodule : ivm_cmd_core
`default_nettype wire

// ### verilog/ivm_pkg.sv
// Shared constants and carriers for the vector/return/move-event interpreter slice.
// Assumes frames arrive already assembled as nine bytes by a byte link outside.
`default_nettype none
package ivm_pkg;

  // Opcodes
  localparam logic [7:0] OP_MOVE_TO_POS   = 8'h04;
  localparam logic [7:0] OP_IRQ_ENABLE    = 8'h19;
  localparam logic [7:0] OP_IRQ_DISABLE   = 8'h1A;
  localparam logic [7:0] OP_DEFINE_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN_HANDLER = 8'h26;
  localparam logic [7:0] OP_USER_FIRST    = 8'h40;
  localparam logic [7:0] OP_USER_LAST     = 8'h47;
  localparam logic [7:0] OP_POS_EVENT     = 8'h8A;

  // Status codes and addresses
  localparam logic [7:0] ST_OK            = 8'h64;
  localparam logic [7:0] ST_POS_REACHED   = 8'h80;
  localparam logic [7:0] ST_BAD_CHECKSUM  = 8'h01;
  localparam logic [7:0] ST_BAD_OPCODE    = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE      = 8'h03;
  localparam logic [7:0] HOST_ADDR        = 8'h02;
  localparam logic [7:0] MODULE_ADDR      = 8'h01;

  // Field values
  localparam logic [7:0] IRQ_GLOBAL       = 8'hFF;
  localparam logic [7:0] EVT_TYPE_ONCE    = 8'h00;
  localparam logic [7:0] EVT_TYPE_EVERY   = 8'h01;
  localparam int         MOTOR_BIT        = 0;
  localparam int         IRQ_COUNT        = 16;
  localparam int         IRQ_IDX_W        = 4;
  localparam int         PC_W             = 16;
  localparam int         FRAME_BYTES      = 9;

  // Command frame, bytes in wire order
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  opcode;
    logic [7:0]  kind;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  checksum;
  } ivm_cmd_t;

  // Reply frame, bytes in wire order
  typedef struct packed {
    logic [7:0]  host;
    logic [7:0]  target;
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [31:0] value;
    logic [7:0]  checksum;
  } ivm_reply_t;

  // Interpreter context saved on handler entry
  typedef struct packed {
    logic [31:0]     accu;
    logic [31:0]     xreg;
    logic [7:0]      flags;
    logic [PC_W-1:0] pc;
  } ivm_ctx_t;

endpackage : ivm_pkg
`default_nettype wire

// ### verilog/ivm_sum8.sv
// Modulo-256 sum of the first eight bytes of a nine-byte frame.
// Purely combinational; used for checking commands and sealing replies.
`timescale 1ns/10ps
`default_nettype none
module ivm_sum8 (
  // Frame in
  input  wire logic [71:0] frame,
  // Sum out
  output logic      [7:0]  sum
);
  logic [10:0] acc;

  always_comb begin
    acc = '0;
    for (int i = 1; i < 9; i++) begin
      acc = acc + {3'b000, frame[i*8 +: 8]};
    end
    sum = acc[7:0];
  end
endmodule : ivm_sum8
`default_nettype wire

// ### sim/ivm_cmd_core_assertions.sv
// Concurrent checks on the command core's frame and handler ports.
// Assumes one clock domain and a bind from the bench's top file.
`timescale 1ns/10ps
`default_nettype none
module ivm_cmd_core_assertions (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset_n,
  // Frames
  input wire logic                       cmd_valid,
  input wire ivm_pkg::ivm_cmd_t          cmd,
  input wire logic                       cmd_ready,
  input wire logic                       reply_valid,
  input wire ivm_pkg::ivm_reply_t        reply,
  input wire logic                       reply_ready,
  // Program side
  input wire logic                       pc_load,
  input wire logic [ivm_pkg::PC_W-1:0]   pc_value,
  input wire logic                       ctx_restore,
  input wire ivm_pkg::ivm_ctx_t          ctx_saved,
  input wire logic                       in_handler,
  input wire logic                       user_fn_strobe,
  input wire logic [2:0]                 user_fn_index
);
  function automatic logic [7:0] sum8(input logic [71:0] f);
    sum8 = 8'h00;
    for (int i = 1; i < 9; i++) sum8 += f[i*8 +: 8];
  endfunction : sum8

  wire take   = cmd_valid && cmd_ready;
  wire sum_ok = sum8(cmd) == cmd.checksum;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_take(logic [7:0] op);
    take && sum_ok && cmd.opcode == op;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_ready_idle: assert property (cmd_ready == !reply_valid)
    else $error("ready while reply pending");
  a_reply_next: assert property (take |=> reply_valid)
    else $error("no reply after frame");
  // Reply must not change under a stalled sender
  a_reply_hold: assert property (reply_valid && !reply_ready |=> reply_valid && $stable(reply))
    else $error("reply changed while stalled");
  a_reply_sum: assert property (reply_valid |-> reply.checksum == sum8(reply))
    else $error("reply checksum wrong");
  a_reply_addr: assert property (reply_valid |-> reply.host == 8'h02 && reply.target == 8'h01)
    else $error("reply addresses wrong");
  a_bad_sum: assert property (take && !sum_ok |=> reply.status == 8'h01)
    else $error("bad sum not refused");
  a_event_ack: assert property (s_take(8'h8A) ##0 cmd.kind <= 8'h01 |=>
      reply.status == 8'h64 && reply.opcode == 8'h8A &&
      reply.value == {31'h0000_0000, $past(cmd.value[0])})
    else $error("event ack wrong");
  a_user_fn: assert property (take && sum_ok && cmd.opcode inside {[8'h40:8'h47]} |=>
      user_fn_strobe && user_fn_index == $past(cmd.opcode[2:0]) && reply.status == 8'h64)
    else $error("user function not issued");
  a_late_reply: assert property (reply_valid && reply.status == 8'h80 |->
      reply.opcode == 8'h8A && reply.value[31:8] == 24'h00_0000)
    else $error("deferred reply fields wrong");
  a_reply_drop: assert property (reply_valid && reply_ready |=> !reply_valid)
    else $error("reply did not leave");
  a_vector_ok: assert property (s_take(8'h25) |=> reply.status == 8'h64)
    else $error("vector not acknowledged");
  a_return_pair: assert property (ctx_restore |-> pc_load && pc_value == ctx_saved.pc)
    else $error("return without resume");
  a_entry_jump: assert property ($rose(in_handler) |-> pc_load && !ctx_restore)
    else $error("handler entered without jump");
endmodule : ivm_cmd_core_assertions
`default_nettype wire

// ### sim/ivm_host_model.sv
// Host side of the reply channel: accepts reply frames, may stall.
// Assumes the bench drives stall just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ivm_host_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Reply channel
  input  wire logic                reply_valid,
  input  wire ivm_pkg::ivm_reply_t reply,
  output logic                     reply_ready,
  // Bench side
  input  wire logic                stall,
  output ivm_pkg::ivm_reply_t      last,
  output int                       got_n
);
  // Ready is a level, so a stall leaves the reply standing
  assign reply_ready = !stall;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      got_n <= 0;
      last  <= '0;
    end else if (reply_valid && reply_ready) begin
      got_n <= got_n + 1;
      last  <= reply;
    end
  end
endmodule : ivm_host_model
`default_nettype wire

// ### sim/irq_vector_and_move_event_tb_top.sv
// Directed bench for the command core: frames, handlers, move events.
// Assumes the host model answers replies and the checker is bound here.
`timescale 1ns/10ps
`default_nettype none
module irq_vector_and_move_event_tb_top;
  localparam logic [71:0]      FULL = '1;
  localparam logic [71:0]      HEAD = {32'hFFFF_FFFF, 40'h00_0000_0000};
  localparam logic [71:0]      STM  = {16'h0000, 8'hFF, 48'h0000_0000_0000};
  localparam ivm_pkg::ivm_ctx_t CTX = {32'h1111_2222, 32'h3333_4444, 8'h5A, 16'h0123};
  logic clk = 0, reset_n = 0, cmd_valid = 0, prog_valid = 0, stall = 0;
  logic move_start = 0, move_done = 0, cmd_ready, reply_valid, reply_ready;
  logic pc_load, ctx_restore, in_handler, user_fn_strobe;
  ivm_pkg::ivm_cmd_t   cmd = '0, prog_cmd = '0;
  ivm_pkg::ivm_reply_t reply, last;
  ivm_pkg::ivm_ctx_t   ctx_live = '0, ctx_saved;
  logic [15:0]         irq_event = '0, pc_value;
  logic [2:0]          user_fn_index;
  logic [31:0]         user_fn_result = '0;
  int                  err_total = 0, checked = 0, base = 0, got_n;

  ivm_cmd_core DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply(reply),
    .reply_ready(reply_ready), .prog_valid(prog_valid), .prog_cmd(prog_cmd),
    .ctx_live(ctx_live), .irq_event(irq_event), .pc_load(pc_load), .pc_value(pc_value),
    .ctx_restore(ctx_restore), .ctx_saved(ctx_saved), .in_handler(in_handler),
    .user_fn_strobe(user_fn_strobe), .user_fn_index(user_fn_index),
    .user_fn_result(user_fn_result), .move_start(move_start), .move_done(move_done));
  ivm_host_model HOST (.clk(clk), .reset_n(reset_n), .reply_valid(reply_valid),
    .reply(reply), .reply_ready(reply_ready), .stall(stall), .last(last), .got_n(got_n));

  initial forever #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sum8(input logic [71:0] f);
    sum8 = 8'h00;
    for (int i = 1; i < 9; i++) sum8 += f[i*8 +: 8];
  endfunction : sum8

  function automatic logic [71:0] exp_r(input logic [7:0] st, op, input logic [31:0] v);
    exp_r = {8'h02, 8'h01, st, op, v, 8'h00};
    exp_r[7:0] = sum8(exp_r);
  endfunction : exp_r

  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      err_total++;
      tally_and_finish();
    end
  endtask : bound

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Frame held until the edge that takes it
  task automatic send(input logic [7:0] op, k, input logic [31:0] v, input logic bad);
    int i;
    cmd = '{8'h01, op, k, 8'h00, v, 8'h00};
    cmd.checksum = sum8(cmd) + 8'(bad);
    cmd_valid = 1;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) tick(1);
    bound(i, 20);
    tick(1);
    cmd_valid = 0;
  endtask : send

  task automatic expect_r(input logic [71:0] e, input logic [71:0] m);
    int i;
    for (i = 0; i < 50 && got_n == base; i++) tick(1);
    bound(i, 50);
    base = got_n;
    cmp(last & m, e & m);
  endtask : expect_r

  task automatic none(input int k);
    tick(k);
    cmp(got_n - base, 0);
  endtask : none

  task automatic xact(input logic [7:0] op, k, st, input logic [31:0] v, rv,
                      input logic [71:0] m, input logic bad = 0);
    send(op, k, v, bad);
    expect_r(exp_r(st, op, rv), m);
  endtask : xact

  task automatic pulse_irq();
    irq_event[3] = 1;
    tick(1);
    irq_event[3] = 0;
  endtask : pulse_irq

  task automatic prog(input logic [7:0] op, k);
    prog_cmd = '{8'h01, op, k, 8'h00, 32'h0000_0001, 8'h00};
    prog_valid = 1;
    tick(1);
    prog_valid = 0;
  endtask : prog

  task automatic move();
    move_start = 1;
    tick(1);
    move_start = 0;
    tick(3);
    move_done = 1;
    tick(1);
    move_done = 0;
  endtask : move

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_errors();
    xact(8'h25, 8'h00, ivm_pkg::ST_BAD_CHECKSUM, 0, 0, STM, 1);
    xact(8'h30, 8'h00, ivm_pkg::ST_BAD_OPCODE, 0, 0, STM);
    xact(8'h26, 8'hFF, ivm_pkg::ST_OK, 0, 0, HEAD);
  endtask : t_errors

  task automatic t_user();
    for (int i = 0; i < 8; i++) begin
      user_fn_result = 32'hC0DE_0000 + i;
      send(8'(8'h40 + i), 8'(i), i, 1'b0);
      cmp({user_fn_strobe, user_fn_index}, {1'b1, 3'(i)});
      expect_r(exp_r(ivm_pkg::ST_OK, 8'(8'h40 + i), user_fn_result), FULL);
    end
  endtask : t_user

  task automatic t_irq();
    int i;
    xact(8'h25, 8'h03, ivm_pkg::ST_OK, 32'h0000_0050, 0, HEAD);
    xact(8'h19, 8'h03, ivm_pkg::ST_OK, 0, 0, HEAD);
    xact(8'h19, 8'hFF, ivm_pkg::ST_OK, 0, 0, HEAD);
    ctx_live = CTX;
    pulse_irq();
    for (i = 0; i < 10 && pc_load !== 1'b1; i++) tick(1);
    bound(i, 10);
    cmp(pc_value, 16'h0050);
    tick(1);
    cmp({in_handler, ctx_saved}, {1'b1, CTX});
    ctx_live = '1;
    prog(8'h26, 8'hFF);
    for (i = 0; i < 10 && ctx_restore !== 1'b1; i++) tick(1);
    bound(i, 10);
    cmp({pc_load, pc_value, ctx_saved}, {1'b1, CTX.pc, CTX});
    tick(2);
    cmp(in_handler, 0);
    xact(8'h1A, 8'hFF, ivm_pkg::ST_OK, 0, 0, HEAD);
    pulse_irq();
    for (i = 0; i < 10 && pc_load !== 1'b1; i++) tick(1);
    cmp(i, 10);
  endtask : t_irq

  task automatic t_event();
    xact(8'h8A, 8'h00, ivm_pkg::ST_OK, 1, 1, FULL);
    move();
    expect_r(exp_r(8'h80, 8'h8A, 1), FULL);
    move();
    none(10);
    xact(8'h8A, 8'h02, ivm_pkg::ST_BAD_TYPE, 1, 0, STM);
    move();
    none(10);
    prog(8'h8A, 8'h01);
    move();
    none(10);
    xact(8'h8A, 8'h01, ivm_pkg::ST_OK, 1, 1, FULL);
    // Stall the host so the deferred reply must wait
    stall = 1;
    move();
    tick(5);
    cmp(reply_valid, 1);
    stall = 0;
    expect_r(exp_r(8'h80, 8'h8A, 1), FULL);
    move();
    expect_r(exp_r(8'h80, 8'h8A, 1), FULL);
  endtask : t_event

  initial begin
    tick(4);
    reset_n = 1;
    t_errors();
    t_user();
    t_irq();
    t_event();
    tally_and_finish();
  end
endmodule : irq_vector_and_move_event_tb_top

bind ivm_cmd_core ivm_cmd_core_assertions CHK (.clk, .reset_n, .cmd_valid, .cmd,
  .cmd_ready, .reply_valid, .reply, .reply_ready, .pc_load, .pc_value, .ctx_restore,
  .ctx_saved, .in_handler, .user_fn_strobe, .user_fn_index);
`default_nettype wire
